// file: logic/pebm_pkg.sv
// constants and carrier types for the multiplexed bidirectional port
package pebm_pkg;
  localparam int          PEBM_AW          = 3;          // register address width
  localparam int          PEBM_DW          = 8;          // register and port width
  // register offsets
  localparam logic [2:0]  PEBM_OFF_PIN     = 3'h0;       // port_pin_data
  localparam logic [2:0]  PEBM_OFF_LAT     = 3'h1;       // output latch
  localparam logic [2:0]  PEBM_OFF_DIR     = 3'h2;       // port_direction
  localparam logic [2:0]  PEBM_OFF_MEMCTL  = 3'h3;       // memory_interface_control
  localparam logic [2:0]  PEBM_OFF_NBLAT   = 3'h4;       // neighbour_latch_register
  localparam logic [2:0]  PEBM_OFF_SPCTL   = 3'h5;       // slave_port_control
  // field positions
  localparam int          PEBM_EXT_BUS_DISABLE_BIT   = 7;          // ext_bus_disable
  localparam int          PEBM_PU_BIT      = 6;          // pullup_enable
  localparam int          PEBM_SPMODE_BIT  = 4;          // slave_port_mode
  // package variants in pins
  localparam int          PEBM_PKG_SMALL   = 64;
  localparam int          PEBM_PKG_MID     = 80;
  localparam int          PEBM_PKG_LARGE   = 100;
  localparam int          PEBM_W_SMALL     = 6;          // port width, smallest package
  localparam int          PEBM_W_LARGE     = 8;          // port width, larger packages
  // reset values
  localparam logic [7:0]  PEBM_RST_LAT     = 8'h00;
  localparam logic        PEBM_RST_EXT_BUS_DISABLE   = 1'b1;
  localparam logic        PEBM_RST_PU      = 1'b0;
  localparam logic        PEBM_RST_SPMODE  = 1'b0;
  localparam logic [7:0]  PEBM_ZERO        = 8'h00;
  localparam int          PEBM_SMALL_D0_CH = 6;          // channel moved to neighbour pin

  // enhanced pwm channels, index = pin (7 is capture/compare 2 and pwm2_out_a)
  typedef struct packed {
    logic [7:0] val;                                     // channel output level
    logic [7:0] en;                                      // channel owns its pin
    logic [7:0] tri_st;                                  // shutdown tri-state request
  } pebm_pwm_t;

  // external memory interface, high address/data byte
  typedef struct packed {
    logic [7:0] ad_out;                                  // bus value to drive
    logic [7:0] ad_oe;                                   // bus drives the pin
  } pebm_ebus_t;

  // all state of the port
  typedef struct packed {
    logic [7:0] lat;                                     // output latch
    logic [7:0] dir;                                     // 1 = input
    logic       ext_bus_disable;                                   // memory interface off
    logic       pu;                                      // weak pull-up enable
    logic       spmode;                                  // slave port mode
    logic [7:0] pin_q;                                   // sampled pin levels
    logic [7:0] rdata;                                   // read data
    logic [7:0] pin_o;                                   // pin output values
    logic [7:0] pin_oe;                                  // pin output enables
    logic [7:0] pull;                                    // pull-up per pin
    logic [2:0] spctl;                                   // slave port rd, wr, cs
    logic [7:0] ebus_din;                                // data to memory interface
    logic       d0_o;                                    // neighbour pin 0 value
    logic       d0_oe;                                   // neighbour pin 0 enable
  } pebm_state_t;
endpackage

// file: logic/pebm_port.sv
// multiplexed bidirectional port with memory bus, slave port and pwm sharing
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pebm_port
  import pebm_pkg::*;
#(
  parameter int PKG_PINS = pebm_pkg::PEBM_PKG_LARGE      // 64, 80 or 100
) (
  input  wire logic                    mclk_in,          // 20 MHz system clock
  input  wire logic                    sys_rst_in,       // async, active high
  input  wire logic                    ce_in,            // low freezes all state
  input  wire logic [pebm_pkg::PEBM_AW-1:0] addr_in,     // register address
  input  wire logic [7:0]              wr_data_in,       // write data
  input  wire logic                    wr_stb_in,        // write strobe
  input  wire logic                    rd_stb_in,        // read strobe
  output logic      [7:0]              rd_data_out,      // read data, next cycle
  input  wire logic [7:0]              pin_in,           // pin levels
  output logic      [7:0]              pin_out,          // pin drive values
  output logic      [7:0]              pin_oe_out,       // pin driven when high
  output logic      [7:0]              pullup_out,       // weak pull-up on
  input  wire pebm_pkg::pebm_pwm_t     pwm_in,           // pwm channels
  input  wire logic                    pwm_mux_select_in,     // config bit
  input  wire logic                    capcomp2_mux_select_in, // config bit
  input  wire logic                    micro_mode_in,    // microcontroller mode
  input  wire pebm_pkg::pebm_ebus_t    ebus_in,          // memory interface drive
  output logic      [7:0]              ebus_din_out,     // pins to memory interface
  output logic                         ebus_active_out,  // memory bus owns pins
  output logic      [2:0]              spctl_out,        // slave rd, wr, cs inputs
  output logic                         d0_pwm_out,       // neighbour pin 0 value
  output logic                         d0_pwm_oe_out     // neighbour pin 0 enable
);
  import pebm_pkg::*;

  // implemented bits of the port for a package variant
  function automatic logic [7:0] impl_mask(input int pins);
    impl_mask = (pins == PEBM_PKG_SMALL) ? 8'h3f : 8'hff;
  endfunction

  localparam logic [7:0] MASK  = impl_mask(PKG_PINS);
  localparam logic       LARGE = (PKG_PINS == PEBM_PKG_LARGE);
  localparam logic       SMALL = (PKG_PINS == PEBM_PKG_SMALL);

  // refuse package variants the mapping does not know, at elaboration
  // a wrong variant would silently pick the 80-pin map otherwise
  if (PKG_PINS != PEBM_PKG_SMALL && PKG_PINS != PEBM_PKG_MID &&
      PKG_PINS != PEBM_PKG_LARGE) begin : g_bad_pkg
    $error("pebm_port: PKG_PINS must be 64, 80 or 100");
  end

  pebm_state_t s_ff;                                     // registered state
  pebm_state_t nxt_s;                                    // next state
  logic        bus_on;                                   // memory bus owns pins
  logic        psp_on;                                   // slave port active
  logic [7:0]  ch_ok;                                    // channel mapped to pin

  // mode decode from the control bits
  always_comb begin
    bus_on = LARGE && !s_ff.ext_bus_disable;
    psp_on = LARGE && s_ff.spmode;
    // default channels: pins 0-2 pwm2 d,c,b always
    ch_ok = 8'h07;
    if (SMALL) begin
      ch_ok[5:3] = 3'h7;
    end else begin
      ch_ok[6:3] = {4{pwm_mux_select_in}};
      ch_ok[7]   = !capcomp2_mux_select_in && micro_mode_in;
    end
  end

  // next state: register file, pin muxing, sampling
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.pin_q = pin_in & MASK;
    nxt_s.rdata = PEBM_ZERO;                             // data only after a read
    // register writes
    if (wr_stb_in) begin
      if (addr_in == PEBM_OFF_PIN || addr_in == PEBM_OFF_LAT) begin
        nxt_s.lat = wr_data_in & MASK;
      end else if (addr_in == PEBM_OFF_DIR) begin
        nxt_s.dir = wr_data_in & MASK;
      end else if (addr_in == PEBM_OFF_MEMCTL) begin
        nxt_s.ext_bus_disable = wr_data_in[PEBM_EXT_BUS_DISABLE_BIT];
      end else if (addr_in == PEBM_OFF_NBLAT) begin
        nxt_s.pu = wr_data_in[PEBM_PU_BIT];
      end else if (addr_in == PEBM_OFF_SPCTL) begin
        nxt_s.spmode = wr_data_in[PEBM_SPMODE_BIT];
      end
    end
    // register reads, unmapped reads give zero
    if (rd_stb_in) begin
      if (addr_in == PEBM_OFF_PIN) begin
        nxt_s.rdata = s_ff.pin_q;
      end else if (addr_in == PEBM_OFF_LAT) begin
        nxt_s.rdata = s_ff.lat;
      end else if (addr_in == PEBM_OFF_DIR) begin
        nxt_s.rdata = s_ff.dir;
      end else if (addr_in == PEBM_OFF_MEMCTL) begin
        nxt_s.rdata[PEBM_EXT_BUS_DISABLE_BIT] = s_ff.ext_bus_disable;
      end else if (addr_in == PEBM_OFF_NBLAT) begin
        nxt_s.rdata[PEBM_PU_BIT] = s_ff.pu;
      end else if (addr_in == PEBM_OFF_SPCTL) begin
        nxt_s.rdata[PEBM_SPMODE_BIT] = s_ff.spmode;
      end
    end
    // per pin driver, highest priority first
    for (int i = 0; i < 8; i++) begin
      if (bus_on) begin
        // memory bus ignores direction bits
        nxt_s.pin_o[i]  = ebus_in.ad_out[i];
        nxt_s.pin_oe[i] = ebus_in.ad_oe[i];
      end else if (psp_on && i < 3) begin
        // control inputs, driven in slave mode only by the memory bus
        nxt_s.pin_o[i]  = s_ff.lat[i];
        nxt_s.pin_oe[i] = 1'b0;
      end else if (!s_ff.dir[i] && ch_ok[i] && pwm_in.en[i]) begin
        nxt_s.pin_o[i]  = pwm_in.val[i];
        nxt_s.pin_oe[i] = !pwm_in.tri_st[i];
      end else begin
        nxt_s.pin_o[i]  = s_ff.lat[i];
        nxt_s.pin_oe[i] = !s_ff.dir[i];
      end
    end
    nxt_s.pin_o  = nxt_s.pin_o & MASK;
    nxt_s.pin_oe = nxt_s.pin_oe & MASK;
    // pull-ups follow the driver decision, so an output never pulls
    nxt_s.pull = {8{s_ff.pu}} & ~nxt_s.pin_oe & MASK;
    // slave port controls only on the largest package
    nxt_s.spctl    = psp_on ? s_ff.pin_q[2:0] : 3'h0;
    nxt_s.ebus_din = bus_on ? s_ff.pin_q : PEBM_ZERO;
    // smallest package moves one channel to the neighbour pin
    nxt_s.d0_o  = SMALL && pwm_in.en[PEBM_SMALL_D0_CH] &&
                  pwm_in.val[PEBM_SMALL_D0_CH];
    nxt_s.d0_oe = SMALL && pwm_in.en[PEBM_SMALL_D0_CH] &&
                  !pwm_in.tri_st[PEBM_SMALL_D0_CH];
  end

  // state register; reset leaves pins as inputs with no pull-ups
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_ff        <= '0;
      s_ff.lat    <= PEBM_RST_LAT;
      s_ff.dir    <= MASK;
      s_ff.ext_bus_disable  <= PEBM_RST_EXT_BUS_DISABLE;
      s_ff.pu     <= PEBM_RST_PU;
      s_ff.spmode <= PEBM_RST_SPMODE;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state flops, except ebus_active_out, decoded from ext_bus_disable
  assign rd_data_out     = s_ff.rdata;
  assign pin_out         = s_ff.pin_o;
  assign pin_oe_out      = s_ff.pin_oe;
  assign pullup_out      = s_ff.pull;
  assign spctl_out       = s_ff.spctl;
  assign ebus_din_out    = s_ff.ebus_din;
  assign ebus_active_out = bus_on;
  assign d0_pwm_out      = s_ff.d0_o;
  assign d0_pwm_oe_out   = s_ff.d0_oe;

  // helper: high until the first enabled register read or write after reset
  logic fresh_ff;                                        // no register access since reset
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fresh_ff <= 1'b1;
    end else if (ce_in && (wr_stb_in || rd_stb_in)) begin
      fresh_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // a write to pin data followed by a latch read
  sequence wr_pin_s;
    ce_in && wr_stb_in && addr_in == PEBM_OFF_PIN;
  endsequence
  sequence rd_lat_s;
    ce_in && rd_stb_in && addr_in == PEBM_OFF_LAT;
  endsequence
  sequence psp_s;
    ce_in && psp_on && !bus_on;
  endsequence

  AST_RESET_STATE: assert property (fresh_ff |-> s_ff.dir == MASK && !s_ff.pu)
    else $error("reset did not leave inputs without pull-ups");
  AST_ALL_INPUT: assert property (
    (ce_in && !bus_on && s_ff.dir == MASK) |=> pin_oe_out == 8'h00)
    else $error("input pin is driven");
  AST_LATCH_DRIVE: assert property (
    (ce_in && !bus_on && !psp_on && s_ff.dir == 8'h00 && pwm_in.en == 8'h00)
    |=> pin_out == $past(s_ff.lat) && pin_oe_out == MASK)
    else $error("output pin does not show latch");
  AST_LATCH_READ: assert property (rd_lat_s |=> rd_data_out == $past(s_ff.lat))
    else $error("latch read wrong");
  AST_PIN_TO_LATCH: assert property (
    wr_pin_s ##1 rd_lat_s |=> rd_data_out == ($past(wr_data_in, 2) & MASK))
    else $error("pin data write did not reach latch");
  AST_BUS_PRIO: assert property (
    (ce_in && bus_on) |=> pin_out == $past(ebus_in.ad_out)
    && pin_oe_out == $past(ebus_in.ad_oe))
    else $error("memory bus lost the pins");
  AST_NO_PULL_OUT: assert property ((pullup_out & pin_oe_out) == 8'h00)
    else $error("pull-up on a driven pin");
  AST_PSP_INPUTS: assert property (
    psp_s |=> pin_oe_out[2:0] == 3'h0 && spctl_out == $past(s_ff.pin_q[2:0]))
    else $error("slave port controls wrong");
  AST_PWM_PRIO: assert property (
    (ce_in && !bus_on && !psp_on && !s_ff.dir[0] && pwm_in.en[0] && !pwm_in.tri_st[0])
    |=> pin_out[0] == $past(pwm_in.val[0]) && pin_oe_out[0])
    else $error("pwm lost pin 0");
  AST_HIGH_ZERO: assert property (
    (ce_in && rd_stb_in && addr_in <= PEBM_OFF_DIR) |=> (rd_data_out & ~MASK) == 8'h00)
    else $error("unimplemented bits read nonzero");
  AST_READ_ONCE: assert property ((ce_in && !rd_stb_in) |=> rd_data_out == 8'h00)
    else $error("read data outside its cycle");

  // --- register write paths ---
  // each write lands in the state one edge later, latch and direction masked to the width

  // a pin data write, one idle cycle, then a latch read
  // this is the spacing the simple bus master produces most often
  sequence wr_gap_rd_s;
    wr_pin_s ##1 (ce_in && !wr_stb_in) ##1 rd_lat_s;
  endsequence

  AST_PIN_TO_LATCH_GAP: assert property (
    wr_gap_rd_s |=> rd_data_out == ($past(wr_data_in, 3) & MASK))
    else $error("pin data write lost before latch read");

  // latch write through its own offset
  sequence wr_lat_s;
    ce_in && wr_stb_in && addr_in == PEBM_OFF_LAT;
  endsequence

  AST_LAT_WRITE: assert property (
    wr_lat_s |=> s_ff.lat == ($past(wr_data_in) & MASK))
    else $error("latch write did not land");

  // direction write, unimplemented bits stay clear
  sequence wr_dir_s;
    ce_in && wr_stb_in && addr_in == PEBM_OFF_DIR;
  endsequence

  AST_DIR_WRITE: assert property (
    wr_dir_s |=> s_ff.dir == ($past(wr_data_in) & MASK))
    else $error("direction write did not land");

  // the one pull-up enable bit in the neighbour latch
  sequence wr_pu_s;
    ce_in && wr_stb_in && addr_in == PEBM_OFF_NBLAT;
  endsequence

  AST_PU_WRITE: assert property (
    wr_pu_s |=> s_ff.pu == $past(wr_data_in[PEBM_PU_BIT]))
    else $error("pull-up enable write did not land");

  // --- pull-ups ---

  // all pins inputs and enable set: every implemented pin pulls
  AST_PULL_ALL: assert property (
    (ce_in && s_ff.pu && !bus_on && !psp_on && s_ff.dir == MASK)
    |=> pullup_out == MASK)
    else $error("pull-ups not on for all inputs");

  // enable clear: nothing pulls, whatever the directions
  AST_PULL_OFF: assert property ((ce_in && !s_ff.pu) |=> pullup_out == 8'h00)
    else $error("pull-up on while enable clear");

  // --- memory bus ---

  // pins are handed to the bus side only while it owns them
  AST_EBUS_DIN: assert property (
    (ce_in && bus_on) |=> ebus_din_out == $past(s_ff.pin_q))
    else $error("bus input data wrong");

  // bus off or absent: nothing leaks to the bus side
  AST_EBUS_IDLE: assert property ((ce_in && !bus_on) |=> ebus_din_out == 8'h00)
    else $error("bus input data while bus off");

  // --- slave port and pwm ---

  // slave controls stay quiet outside slave mode
  AST_SPCTL_IDLE: assert property ((ce_in && !psp_on) |=> spctl_out == 3'h0)
    else $error("slave controls outside slave mode");

  // shutdown tri-states a pwm-owned pin even with direction zero
  AST_PWM_SHUT: assert property (
    (ce_in && !bus_on && !psp_on && !s_ff.dir[0] && pwm_in.en[0] && pwm_in.tri_st[0])
    |=> !pin_oe_out[0])
    else $error("pwm shutdown did not tri-state pin 0");

  // pin 7 carries pwm2_out_a only when routed there
  sequence pin7_pwm_s;
    ce_in && !bus_on && !s_ff.dir[7] && ch_ok[7] && pwm_in.en[7];
  endsequence

  AST_CH7_ROUTE: assert property (
    pin7_pwm_s |=> pin_out[7] == $past(pwm_in.val[7]))
    else $error("pin 7 lost routed pwm");

  // not routed: pin 7 is a plain latch output again
  AST_CH7_HOME: assert property (
    (ce_in && !bus_on && !s_ff.dir[7] && !ch_ok[7])
    |=> pin_out[7] == $past(s_ff.lat[7]))
    else $error("pin 7 not showing latch");

  // pwm mux clear gives pin 3 back to the latch on larger packages
  AST_MUX_HOME: assert property (
    (ce_in && LARGE && !bus_on && !pwm_mux_select_in && !s_ff.dir[3])
    |=> pin_out[3] == $past(s_ff.lat[3]))
    else $error("pin 3 still owned by pwm");

  // --- bus side housekeeping ---

  // unmapped offsets read zero
  AST_UNMAPPED: assert property (
    (ce_in && rd_stb_in && addr_in > PEBM_OFF_SPCTL) |=> rd_data_out == 8'h00)
    else $error("unmapped read nonzero");

  // clock enable low holds every state bit
  AST_FREEZE: assert property (!ce_in |=> s_ff == $past(s_ff))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// file: testbench/pebm_board_model.sv
// board side of the port: external drivers, pull-ups and floating pins
`timescale 1ns/1ps
`default_nettype none
module pebm_board_model (
  input  wire logic       mclk_in,    // system clock
  input  wire logic [7:0] dev_out_in, // device drive values
  input  wire logic [7:0] dev_oe_in,  // device drives pin
  input  wire logic [7:0] pull_in,    // weak pull-up on
  input  wire logic [7:0] ext_val_in, // board driver values
  input  wire logic [7:0] ext_en_in,  // board drives pin
  output logic      [7:0] pin_out     // resolved pin levels
);
  logic [7:0] flt_ff = 8'h5a;         // level of an undriven pin
  // a floating pin wanders, so a stale level never passes as data
  always @(posedge mclk_in) flt_ff <= ~flt_ff;
  // device driver wins, then board driver, then weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dev_oe_in[i]) pin_out[i] = dev_out_in[i];
      else if (ext_en_in[i]) pin_out[i] = ext_val_in[i];
      else if (pull_in[i]) pin_out[i] = 1'b1;
      else pin_out[i] = flt_ff[i];
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_port_e_bidir_io_mux.sv
// self-checking bench for the multiplexed port, large and small package
`timescale 1ns/1ps
`default_nettype none
module test_port_e_bidir_io_mux;
  import pebm_pkg::*;
  logic       mclk_in = 1'b0;    // system clock
  logic       sys_rst_in = 1'b1; // async reset
  logic [2:0] addr = '0;         // register address
  logic [7:0] wdat = '0;         // write data
  logic       wr_stb = 1'b0;     // write strobe
  logic       rd_stb = 1'b0;     // read strobe
  logic [7:0] ext_val = '0;      // board drive values
  logic [7:0] ext_en = '0;       // board drive enables
  logic       pmx = 1'b1;        // pwm mux config bit
  logic       cmx = 1'b0;        // capcomp2 mux config bit
  pebm_pwm_t  pwm = '0;          // pwm channels
  pebm_ebus_t eb = '0;           // memory bus drive
  logic [7:0] pin, rdo, po, oe, pu, edin, rdo_s, oe_s, pu_s;
  logic [2:0] spc, spc_s;        // slave control outputs
  logic       eact, eact_s, d0oe, d0oe_s, d0_s;
  logic       ce = 1'b1;         // clock enable
  logic       mm = 1'b1;         // microcontroller mode
  logic [7:0] rv, rvs;           // last read data, both variants
  int         err_total = 0;     // mismatches
  int         tests_run = 0;     // comparisons
  always #25 mclk_in = ~mclk_in;
  pebm_board_model u_pebm_board_model (.mclk_in(mclk_in), .dev_out_in(po), .dev_oe_in(oe),
    .pull_in(pu), .ext_val_in(ext_val), .ext_en_in(ext_en), .pin_out(pin));
  // largest package instance
  pebm_port u_pebm_port (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
    .addr_in(addr), .wr_data_in(wdat), .wr_stb_in(wr_stb), .rd_stb_in(rd_stb),
    .rd_data_out(rdo), .pin_in(pin), .pin_out(po), .pin_oe_out(oe), .pullup_out(pu),
    .pwm_in(pwm), .pwm_mux_select_in(pmx), .capcomp2_mux_select_in(cmx), .micro_mode_in(mm),
    .ebus_in(eb), .ebus_din_out(edin), .ebus_active_out(eact), .spctl_out(spc),
    .d0_pwm_out(), .d0_pwm_oe_out(d0oe));
  // smallest package instance on the same bus, pins only observed
  pebm_port #(.PKG_PINS(64)) u_pebm_port_small (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .ce_in(ce), .addr_in(addr), .wr_data_in(wdat), .wr_stb_in(wr_stb), .rd_stb_in(rd_stb),
    .rd_data_out(rdo_s), .pin_in(pin), .pin_out(), .pin_oe_out(oe_s), .pullup_out(pu_s),
    .pwm_in(pwm), .pwm_mux_select_in(pmx), .capcomp2_mux_select_in(cmx), .micro_mode_in(mm),
    .ebus_in(eb), .ebus_din_out(), .ebus_active_out(eact_s), .spctl_out(spc_s),
    .d0_pwm_out(d0_s), .d0_pwm_oe_out(d0oe_s));
  // one-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr <= a; wdat <= d; wr_stb <= 1'b1;
    @(posedge mclk_in);
    wr_stb <= 1'b0;
  endtask
  // read; data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge mclk_in);
    addr <= a; rd_stb <= 1'b1;
    @(posedge mclk_in);
    rd_stb <= 1'b0;
    #1 rv = rdo;
    rvs = rdo_s;
  endtask
  // outputs lag the registers by one stage; three edges cover pin sampling too
  task automatic st;
    repeat (3) @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(3'h2); chk("dir", 8'hff, rv);
    chk("dir_s", 8'h3f, rvs);
    rd(3'h3); chk("memctl", 8'h80, rv);
    rd(3'h4); chk("nblat", 8'h00, rv);
    rd(3'h6); chk("unmapped", 8'h00, rv);
    chk("oe", 8'h00, oe);
    chk("pull", 8'h00, pu);
    chk("eact", {7'h0, eact}, 8'h00);
    // one pull-up bit covers every input pin
    wr(3'h4, 8'hff); rd(3'h4); chk("nblat", 8'h40, rv);
    st; chk("pull", 8'hff, pu);
    chk("pull_s", 8'h3f, pu_s);
    rd(3'h0); chk("pins", 8'hff, rv);
    chk("pins_s", 8'h3f, rvs);
    // latch versus pin levels, mixed directions
    @(posedge mclk_in);
    ext_en <= 8'h0f; ext_val <= 8'h3c;
    wr(3'h1, 8'ha5); rd(3'h1); chk("lat", 8'ha5, rv);
    wr(3'h2, 8'h0f); st;
    chk("oe", 8'hf0, oe);
    chk("out", 8'ha0, po & 8'hf0);
    chk("pull", 8'h0f, pu);
    chk("oe_s", 8'h30, oe_s);
    rd(3'h0); chk("pins", 8'hac, rv);
    rd(3'h1); chk("lat", 8'ha5, rv);
    wr(3'h0, 8'h5a); rd(3'h1); chk("lat", 8'h5a, rv);
    // pwm ownership, shutdown, mux config bits
    @(posedge mclk_in);
    ext_en <= 8'h00;
    pwm <= '{val: 8'haa, en: 8'hff, tri_st: 8'h01};
    wr(3'h2, 8'h00); st;
    chk("oe", 8'hfe, oe);
    chk("out", 8'haa, po & 8'hfe);
    chk("oe_s", 8'h3e, oe_s);
    chk("d0oe_s", 8'h01, {7'h0, d0oe_s});
    chk("d0oe", 8'h00, {7'h0, d0oe});
    chk("d0_s", 8'h00, {7'h0, d0_s});
    @(posedge mclk_in);
    pmx <= 1'b0;
    st; chk("out", 8'hda, po & 8'hfe);
    @(posedge mclk_in);
    mm <= 1'b0;
    st; chk("out_mm", 8'h5a, po & 8'hfe);
    @(posedge mclk_in);
    mm <= 1'b1;
    @(posedge mclk_in);
    cmx <= 1'b1;
    st; chk("out", 8'h5a, po & 8'hfe);
    @(posedge mclk_in);
    pwm <= '0; ext_en <= 8'h07; ext_val <= 8'h05;
    // slave port control inputs
    wr(3'h2, 8'h07);
    wr(3'h5, 8'h10); st;
    chk("spc", 8'h05, {5'h0, spc});
    chk("spc_s", 8'h00, {5'h0, spc_s});
    rd(3'h5); chk("spctl", 8'h10, rv);
    wr(3'h2, 8'h00); st; chk("oe", 8'hf8, oe);
    // memory bus takes the pins over slave port and latch
    @(posedge mclk_in);
    ext_en <= 8'h03; ext_val <= 8'h01;
    eb <= '{ad_out: 8'ha5, ad_oe: 8'h3c};
    wr(3'h3, 8'h00); st;
    chk("eact", 8'h01, {7'h0, eact});
    chk("eact_s", 8'h00, {7'h0, eact_s});
    chk("oe", 8'h3c, oe);
    chk("out", 8'h24, po & 8'h3c);
    chk("pull", 8'hc3, pu);
    chk("edin", 8'h25, edin & 8'h3f);
    wr(3'h3, 8'h80); st; chk("oe", 8'hf8, oe);
    // clock enable low: a write must not land
    @(posedge mclk_in);
    ce <= 1'b0;
    wr(3'h1, 8'h33);
    @(posedge mclk_in);
    ce <= 1'b1;
    rd(3'h1); chk("lat_frz", 8'h5a, rv);
    // second reset in mid-run
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(3'h2); chk("dir", 8'hff, rv);
    rd(3'h4); chk("nblat", 8'h00, rv);
    rd(3'h5); chk("spctl", 8'h00, rv);
    end_of_test;
  end
endmodule
`default_nettype wire
